// ===== tb/smx_host_model.sv
// Host terminal and flash stand-in facing the exit and restore interpreter
module smx_host_model (
  input  wire logic       clock,
  output logic            rx_valid,
  output logic      [7:0] rx_char,
  input  wire logic       flash_write,
  output logic            flash_done,
  output logic            flash_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int   flash_lat = 3;
  logic ok_set    = 1'b1;
  initial begin
    rx_valid   = 1'b0;
    rx_char    = 8'h00;
    flash_done = 1'b0;
    flash_ok   = 1'b0;
  end
  // ----------------------------------------------------------------
  // Terminal side
  // ----------------------------------------------------------------
  // Idle data shows the inverse so a stale character never looks valid
  task automatic send_char(input logic [7:0] c);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask
  task automatic send_line(input logic [23:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      send_char(s[23-8*i -: 8]);
    end
    send_char(8'h0D);
  endtask
  // ----------------------------------------------------------------
  // Flash side: latency and result are set by the bench
  // ----------------------------------------------------------------
  initial forever begin
    @(posedge clock);
    if (flash_write === 1'b1) begin
      repeat (flash_lat) @(posedge clock);
      flash_done <= 1'b1;
      flash_ok   <= ok_set;
      @(posedge clock);
      flash_done <= 1'b0;
      flash_ok   <= ~ok_set;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the exit and restore interpreter
`include "smx_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smx_pkg::*;
  // Long enough that an immediate exit can never reach it
  localparam int HOLD = 40;
  logic        clock, srst, rx_valid, params_dirty, flash_done, flash_ok;
  logic [7:0]  rx_char;
  logic [15:0] save_count;
  logic        msg_valid, prompt_valid, service_active, go_normal, go_init;
  logic        reload_flash, load_factory, flash_write;
  logic [3:0]  msg_code;
  logic [3:0]  msgs[$];
  int mismatches, compares, cyc, t_start, t_msg, t_go, n_err, n_ask;
  int n_prompt, n_norm, n_init, n_reload, n_fact, n_fw;
  smx_exit_restore #(.HOLD_CYCLES(HOLD), .SAVE_LIMIT(1000)) dut_u (
    .clock(clock), .srst(srst), .rx_valid(rx_valid), .rx_char(rx_char),
    .params_dirty(params_dirty), .save_count(save_count),
    .flash_done(flash_done), .flash_ok(flash_ok), .msg_valid(msg_valid),
    .msg_code(msg_code), .prompt_valid(prompt_valid),
    .service_active(service_active), .go_normal(go_normal),
    .go_init(go_init), .reload_flash(reload_flash),
    .load_factory(load_factory), .flash_write(flash_write));
  smx_host_model host_u (
    .clock(clock), .rx_valid(rx_valid), .rx_char(rx_char),
    .flash_write(flash_write), .flash_done(flash_done),
    .flash_ok(flash_ok));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Event monitor
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (msg_valid === 1'b1) begin
      msgs.push_back(msg_code);
      if (msg_code == `SMX_MSG_TO_NORM ||
          msg_code == `SMX_MSG_TO_INIT) t_msg = cyc;
      if (msg_code >= 4'h1 && msg_code <= 4'h5) n_err++;
      if (msg_code == `SMX_MSG_MISMATCH) n_ask++;
    end
    if (prompt_valid === 1'b1) n_prompt++;
    if (go_normal === 1'b1) n_norm++;
    if (go_init === 1'b1) n_init++;
    if (go_normal === 1'b1 || go_init === 1'b1) t_go = cyc;
    if (reload_flash === 1'b1) n_reload++;
    if (load_factory === 1'b1) n_fact++;
    if (flash_write === 1'b1) n_fw++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk_code(input string w, input logic [3:0] e,
                          input logic [3:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_cnt(input string w, input int e, input int g);
    compares++;
    if (g != e) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic clear();
    @(negedge clock);
    msgs.delete();
    {n_prompt, n_norm, n_init, n_reload, n_fact, n_fw, n_err, n_ask} = '0;
    t_start = cyc;
    t_msg   = 0;
    t_go    = 0;
  endtask
  task automatic do_reset();
    @(posedge clock);
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    clear();
  endtask
  // Mode 0 waits for a prompt, 1 for the exit, 2 for any message
  task automatic wait_for(input int mode);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clock);
      if ((mode == 0 && n_prompt > 0) || (mode == 2 && msgs.size() > 0) ||
          (mode == 1 && service_active === 1'b0)) break;
    end
    if (i == 400) begin
      mismatches++;
      $display("[FAIL] wait expected done seen timeout");
      print_verdict();
    end
    repeat (3) @(negedge clock);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_exit_now();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      params_dirty <= 1'b1;
      host_u.send_line({"x ", k ? "I" : "N"}, 3);
      wait_for(1);
      chk_cnt("go_normal", k ? 0 : 1, n_norm);
      chk_cnt("go_init", k, n_init);
      chk_cnt("reload", k, n_reload);
      chk_cnt("confirm asked", 0, n_ask);
      chk_cnt("fast exit", 1, int'(t_go - t_start < HOLD));
      chk_cnt("prompts", 0, n_prompt);
    end
    $display("test exit_now done");
  endtask
  task automatic t_exit_hold();
    do_reset();
    params_dirty <= 1'b0;
    host_u.send_line("x n", 3);
    wait_for(1);
    chk_code("target msg", `SMX_MSG_TO_NORM, msgs[0]);
    chk_cnt("go_normal", 1, n_norm);
    chk_cnt("held", 1, int'(t_go - t_msg >= HOLD));
    chk_code("active", 4'h0, {3'h0, service_active});
    $display("test exit_hold done");
  endtask
  task automatic t_exit_confirm();
    do_reset();
    params_dirty <= 1'b1;
    host_u.send_line("x i", 3);
    wait_for(2);
    chk_code("ask msg", `SMX_MSG_MISMATCH, msgs[0]);
    clear();
    host_u.send_char("Y");
    wait_for(1);
    chk_code("target msg", `SMX_MSG_TO_INIT, msgs[0]);
    chk_cnt("go_init", 1, n_init);
    chk_cnt("reload", 1, n_reload);
    chk_cnt("held", 1, int'(t_go - t_msg >= HOLD));
    $display("test exit_confirm done");
  endtask
  task automatic t_confirm_abort();
    logic [7:0] ans[2] = '{"N", "n"};
    do_reset();
    params_dirty <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      host_u.send_line("x n", 3);
      wait_for(2);
      clear();
      host_u.send_char(ans[k]);
      wait_for(0);
      chk_cnt("errors", k, n_err);
      if (k == 1) chk_code("err code", `SMX_MSG_E003, msgs[0]);
      chk_cnt("exits", 0, n_norm + n_init);
      chk_code("active", 4'h1, {3'h0, service_active});
      clear();
    end
    $display("test confirm_abort done");
  endtask
  task automatic t_errors();
    logic [23:0] ln[6] = '{"  q", "  x", "x,n", "x q", "z a", " z,"};
    int          nc[6] = '{1, 1, 3, 3, 3, 2};
    logic [3:0]  ex[6] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2};
    for (int k = 0; k < 6; k++) begin
      clear();
      host_u.send_line(ln[k] << (8 * (3 - nc[k])), nc[k]);
      wait_for(0);
      chk_code("error code", ex[k], msgs[0]);
      chk_cnt("prompt", 1, n_prompt);
    end
    // Five characters overrun the four-character line store
    clear();
    host_u.send_char("x");
    host_u.send_char(" ");
    repeat (3) host_u.send_char("n");
    host_u.send_char(8'h0D);
    wait_for(0);
    chk_code("long line", `SMX_MSG_E002, msgs[0]);
    clear();
    host_u.send_char(8'h0D);
    wait_for(0);
    chk_cnt("empty line msgs", 0, msgs.size());
    chk_cnt("empty line prompt", 1, n_prompt);
    $display("test errors done");
  endtask
  task automatic t_restore();
    do_reset();
    clear();
    host_u.send_line("  z" << 16, 1);
    wait_for(2);
    chk_code("ask msg", `SMX_MSG_FACTORY, msgs[0]);
    host_u.send_char("N");
    wait_for(0);
    chk_cnt("no restore", 0, n_fact);
    clear();
    host_u.send_line("  z" << 16, 1);
    wait_for(2);
    host_u.send_char("Y");
    wait_for(0);
    chk_code("applied", `SMX_MSG_APPLIED, msgs[1]);
    chk_cnt("factory", 1, n_fact);
    chk_cnt("no flash", 0, n_fw);
    for (int k = 0; k < 2; k++) begin
      save_count      <= k ? 16'h0005 : 16'h03E8;
      host_u.ok_set    = k ? 1'b0 : 1'b1;
      host_u.flash_lat = k ? 12 : 2;
      clear();
      host_u.send_line("z s", 3);
      wait_for(2);
      clear();
      host_u.send_char("Y");
      wait_for(0);
      chk_cnt("factory", 1, n_fact);
      chk_cnt("flash write", 1, n_fw);
      chk_code("first msg", k ? 4'h5 : 4'h4, msgs[0]);
      if (k == 0) chk_code("saved", `SMX_MSG_SAVED, msgs[1]);
    end
    $display("test restore done");
  endtask
  initial begin
    srst         = 1'b1;
    params_dirty = 1'b0;
    save_count   = 16'h0000;
    do_reset();
    t_errors();
    t_confirm_abort();
    t_restore();
    t_exit_now();
    t_exit_hold();
    t_exit_confirm();
    print_verdict();
  end
endmodule

// ===== verilog/smx_exit_restore.sv
// Service-mode exit and factory-restore command interpreter
// What this block does
// RQ1 - Lowercase n exit resumes Normal Mode
// RQ2 - Mismatch asks confirmation; only uppercase Y proceeds
// RQ3 - Non-immediate exit waits hold time first
// RQ4 - Lowercase i exit goes via Init Mode
// RQ5 - Init Mode reloads flash, drops unsaved changes
// RQ6 - Uppercase N exits to Normal immediately
// RQ7 - Uppercase I exits to Init immediately
// RQ8 - Unknown command letter gives E001
// RQ9 - Wrong parameter count or comma gives E002
// RQ10 - Parameter outside permitted set gives E003
// RQ11 - Bad confirmation answer aborts with E003
// RQ12 - Answer N aborts quietly to prompt
// RQ13 - Plain restore changes live settings only
// RQ14 - Restore asks confirmation; uppercase Y proceeds
// RQ15 - Restore with s also writes flash
// RQ16 - Characters after plain restore give E002
// RQ17 - Save limit passed warns E004, still saves
// RQ18 - Failed flash write reports E005
// RQ19 - Exit sends target-mode message before leaving; uppercase N and I exits leave without it
// RQ20 - Prompt after each command staying in Service Mode
`include "smx_regs.svh"
module smx_exit_restore
  import smx_pkg::*;
#(
  parameter int HOLD_CYCLES = (`SMX_HOLD_MS * `SMX_CLK_KHZ),
  parameter int SAVE_LIMIT  = `SMX_SAVE_LIMIT
) (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic       params_dirty,
  input  wire logic [15:0] save_count,
  input  wire logic       flash_done,
  input  wire logic       flash_ok,
  output logic            msg_valid,
  output logic      [3:0] msg_code,
  output logic            prompt_valid,
  output logic            service_active,
  output logic            go_normal,
  output logic            go_init,
  output logic            reload_flash,
  output logic            load_factory,
  output logic            flash_write
);
  localparam int AW = $clog2(`SMX_LINE_DEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    smx_state_type state;
    logic [2:0]    len;
    logic          over;
    logic [AW-1:0] rd_idx;
    logic [7:0]    c0;
    logic [7:0]    c1;
    logic [7:0]    c2;
    logic          is_exit;
    logic          to_init;
    logic          do_save;
    logic [31:0]   hold_cnt;
    logic          msg_valid;
    logic [3:0]    msg_code;
    logic          prompt_valid;
    logic          service_active;
    logic          go_normal;
    logic          go_init;
    logic          reload_flash;
    logic          load_factory;
    logic          flash_write;
  } smx_regs_type;

  smx_regs_type state_reg;
  smx_regs_type state_next;
  logic [7:0]   rd_data;

  // Line characters live in the store; the decoder reads them back
  // one per cycle so the store stays a plain registered memory.
  smx_line_mem #(.DEPTH(`SMX_LINE_DEPTH)) u_line (
    .clock   (clock),
    // A full store must not wrap onto the command letter
    .wr_en   (state_reg.state == SMX_COLLECT && rx_valid &&
              rx_char != `SMX_CHR_CR && !state_reg.over &&
              state_reg.len != 3'(`SMX_LINE_DEPTH)),
    .wr_addr (state_reg.len[AW-1:0]),
    .wr_data (rx_char),
    .rd_addr (state_reg.rd_idx),
    .rd_data (rd_data)
  );

  function automatic logic is_exit_opt(input logic [7:0] c);
    return c == `SMX_CHR_LC_N || c == `SMX_CHR_LC_I ||
           c == `SMX_CHR_UC_N || c == `SMX_CHR_UC_I;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.msg_valid    = 1'b0;
    state_next.msg_code     = `SMX_MSG_NONE;
    state_next.prompt_valid = 1'b0;
    state_next.go_normal    = 1'b0;
    state_next.go_init      = 1'b0;
    state_next.reload_flash = 1'b0;
    state_next.load_factory = 1'b0;
    state_next.flash_write  = 1'b0;
    unique case (state_reg.state)
      SMX_IDLE: begin
        // Clear the line length and overflow flag, then collect the next line
        state_next.len  = 3'd0;
        state_next.over = 1'b0;
        state_next.state = SMX_COLLECT;
      end
      SMX_COLLECT: begin
        if (rx_valid) begin
          if (rx_char == `SMX_CHR_CR) begin
            state_next.rd_idx = '0;
            state_next.state  = SMX_DECODE;
            state_next.hold_cnt = 32'd0;
          end else if (state_reg.len == 3'(`SMX_LINE_DEPTH)) begin
            state_next.over = 1'b1;
          end else begin
            state_next.len = state_reg.len + 3'd1;
          end
        end
      end
      SMX_DECODE: begin
        // Read back three characters with one cycle of read latency
        state_next.hold_cnt = state_reg.hold_cnt + 32'd1;
        state_next.rd_idx   = AW'(state_reg.hold_cnt[1:0] + 2'd1);
        if (state_reg.hold_cnt == 32'd1) begin
          state_next.c0 = rd_data;
        end else if (state_reg.hold_cnt == 32'd2) begin
          state_next.c1 = rd_data;
        end else if (state_reg.hold_cnt == 32'd3) begin
          state_next.c2 = rd_data;
        end else if (state_reg.hold_cnt == 32'd4) begin
          state_next.hold_cnt = 32'd0;
          state_next.msg_valid = 1'b1;
          state_next.state = SMX_PROMPT;
          if (state_reg.len == 3'd0) begin
            // Empty line: just prompt again
            state_next.msg_valid = 1'b0;
          end else if (state_reg.c0 == `SMX_CHR_LC_X) begin
            state_next.is_exit = 1'b1;
            state_next.to_init = state_reg.c2 == `SMX_CHR_LC_I ||
                                 state_reg.c2 == `SMX_CHR_UC_I;
            if (state_reg.over || state_reg.len != 3'd3 ||
                state_reg.c1 != `SMX_CHR_SP) begin
              state_next.msg_code = `SMX_MSG_E002; // RQ9
            end else if (!is_exit_opt(state_reg.c2)) begin
              state_next.msg_code = `SMX_MSG_E003; // RQ10
            end else if (state_reg.c2 == `SMX_CHR_UC_N ||
                         state_reg.c2 == `SMX_CHR_UC_I) begin
              state_next.msg_valid = 1'b0;
              state_next.state = SMX_LEAVE; // RQ6 RQ7
            end else if (params_dirty) begin
              state_next.msg_code = `SMX_MSG_MISMATCH; // RQ2
              state_next.state = SMX_WAIT_ANS;
            end else begin
              state_next.msg_valid = 1'b0;
              state_next.state = SMX_ASK;
            end
          end else if (state_reg.c0 == `SMX_CHR_LC_Z) begin
            state_next.is_exit = 1'b0;
            state_next.do_save = state_reg.len == 3'd3;
            if (state_reg.len == 3'd1) begin
              state_next.msg_code = `SMX_MSG_FACTORY; // RQ14
              state_next.state = SMX_WAIT_ANS;
            end else if (state_reg.over || state_reg.len != 3'd3 ||
                         state_reg.c1 != `SMX_CHR_SP) begin
              state_next.msg_code = `SMX_MSG_E002; // RQ16
            end else if (state_reg.c2 != `SMX_CHR_LC_S) begin
              state_next.msg_code = `SMX_MSG_E003; // RQ10
            end else begin
              state_next.msg_code = `SMX_MSG_FACTORY; // RQ14
              state_next.state = SMX_WAIT_ANS;
            end
          end else begin
            state_next.msg_code = `SMX_MSG_E001; // RQ8
          end
        end
      end
      SMX_WAIT_ANS: begin
        if (rx_valid && rx_char != `SMX_CHR_CR) begin
          state_next.msg_valid = 1'b1;
          state_next.state = SMX_PROMPT;
          if (rx_char == `SMX_CHR_UC_Y) begin
            state_next.msg_valid = 1'b0;
            state_next.state = state_reg.is_exit ? SMX_ASK
                                                 : SMX_RESTORE; // RQ2 RQ14
          end else if (rx_char == `SMX_CHR_UC_N) begin
            state_next.msg_code = `SMX_MSG_ABORTED; // RQ12
          end else begin
            state_next.msg_code = `SMX_MSG_E003; // RQ11
          end
        end
      end
      SMX_ASK: begin
        // Announce the target, then hold before leaving
        state_next.msg_valid = 1'b1;
        state_next.msg_code  = state_reg.to_init ? `SMX_MSG_TO_INIT
                                                 : `SMX_MSG_TO_NORM; // RQ19
        state_next.hold_cnt  = 32'd0;
        state_next.state     = SMX_HOLD;
      end
      SMX_HOLD: begin
        state_next.hold_cnt = state_reg.hold_cnt + 32'd1;
        if (state_reg.hold_cnt == 32'(HOLD_CYCLES - 1)) begin
          state_next.state = SMX_LEAVE; // RQ3
        end
      end
      SMX_LEAVE: begin
        state_next.service_active = 1'b0;
        state_next.go_normal    = !state_reg.to_init; // RQ1 RQ6
        state_next.go_init      = state_reg.to_init;  // RQ4 RQ7
        state_next.reload_flash = state_reg.to_init;  // RQ5
        state_next.state = SMX_IDLE;
      end
      SMX_RESTORE: begin
        state_next.load_factory = 1'b1; // RQ13
        state_next.msg_valid = 1'b1;
        if (state_reg.do_save) begin
          state_next.flash_write = 1'b1; // RQ15
          state_next.msg_code = (save_count >= 16'(SAVE_LIMIT)) ?
                                `SMX_MSG_E004 : `SMX_MSG_NONE; // RQ17
          state_next.msg_valid = save_count >= 16'(SAVE_LIMIT);
          state_next.state = SMX_FLASH;
        end else begin
          state_next.msg_code = `SMX_MSG_APPLIED;
          state_next.state = SMX_PROMPT;
        end
      end
      SMX_FLASH: begin
        if (flash_done) begin
          state_next.msg_valid = 1'b1;
          state_next.msg_code = flash_ok ? `SMX_MSG_SAVED
                                         : `SMX_MSG_E005; // RQ18
          state_next.state = SMX_PROMPT;
        end
      end
      SMX_PROMPT: begin
        state_next.prompt_valid = 1'b1; // RQ20
        state_next.state = SMX_IDLE;
      end
      default: begin
        state_next.state = SMX_IDLE;
      end
    endcase
    if (!state_reg.service_active) begin
      state_next.state = SMX_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.state <= SMX_IDLE;
      state_reg.service_active <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign msg_valid      = state_reg.msg_valid;
  assign msg_code       = state_reg.msg_code;
  assign prompt_valid   = state_reg.prompt_valid;
  assign service_active = state_reg.service_active;
  assign go_normal      = state_reg.go_normal;
  assign go_init        = state_reg.go_init;
  assign reload_flash   = state_reg.reload_flash;
  assign load_factory   = state_reg.load_factory;
  assign flash_write    = state_reg.flash_write;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence announce_s;
    msg_valid && (msg_code == `SMX_MSG_TO_NORM ||
                  msg_code == `SMX_MSG_TO_INIT);
  endsequence

  chk_init_reloads: assert property (@(posedge clock) disable iff (srst) // RQ5
    go_init |-> reload_flash) else $error("init without reload");
  chk_exclusive_go: assert property (@(posedge clock) disable iff (srst) // RQ1
    !(go_init && go_normal)) else $error("both targets");
  chk_leave_drops: assert property (@(posedge clock) disable iff (srst) // RQ19
    (go_init || go_normal) |-> !service_active)
    else $error("still active after exit");
  chk_hold_start: assert property (@(posedge clock) disable iff (srst) // RQ3
    announce_s |=> !go_normal && !go_init) else $error("no hold");
  chk_save_write: assert property (@(posedge clock) disable iff (srst) // RQ15
    flash_write |-> load_factory) else $error("save without load");
  chk_prompt_idle: assert property (@(posedge clock) disable iff (srst) // RQ20
    prompt_valid |-> service_active && !msg_valid)
    else $error("bad prompt");
  chk_flash_error: assert property (@(posedge clock) disable iff (srst) // RQ18
    state_reg.state == SMX_FLASH && flash_done && !flash_ok |=>
    msg_valid && msg_code == `SMX_MSG_E005) else $error("no E005");
  chk_bad_answer: assert property (@(posedge clock) disable iff (srst) // RQ11
    state_reg.state == SMX_WAIT_ANS && rx_valid &&
    rx_char != `SMX_CHR_CR && rx_char != `SMX_CHR_UC_Y &&
    rx_char != `SMX_CHR_UC_N |=> msg_code == `SMX_MSG_E003 ##1 prompt_valid)
    else $error("bad answer not refused");

  sequence decode_done_s;
    state_reg.state == SMX_DECODE && state_reg.hold_cnt == 32'd4;
  endsequence

  sequence answer_no_s;
    state_reg.state == SMX_WAIT_ANS && rx_valid &&
    rx_char == `SMX_CHR_UC_N;
  endsequence

  chk_unknown_cmd: assert property (@(posedge clock) disable iff (srst) // RQ8
    decode_done_s ##0 (state_reg.len != 3'd0 &&
    state_reg.c0 != `SMX_CHR_LC_X && state_reg.c0 != `SMX_CHR_LC_Z) |=>
    msg_valid && msg_code == `SMX_MSG_E001) else $error("no E001");
  chk_long_line: assert property (@(posedge clock) disable iff (srst) // RQ9
    decode_done_s ##0 (state_reg.over && state_reg.c0 == `SMX_CHR_LC_X) |=>
    msg_valid && msg_code == `SMX_MSG_E002) else $error("long line kept");
  chk_restore_extra: assert property (@(posedge clock) disable iff (srst) // RQ16
    decode_done_s ##0 (state_reg.c0 == `SMX_CHR_LC_Z &&
    state_reg.len == 3'd2) |=> msg_valid && msg_code == `SMX_MSG_E002)
    else $error("restore extra not refused");
  chk_now_exit: assert property (@(posedge clock) disable iff (srst) // RQ6 RQ7
    decode_done_s ##0 (state_reg.len == 3'd3 && !state_reg.over &&
    state_reg.c0 == `SMX_CHR_LC_X && state_reg.c1 == `SMX_CHR_SP &&
    (state_reg.c2 == `SMX_CHR_UC_N || state_reg.c2 == `SMX_CHR_UC_I)) |=>
    !msg_valid ##1 (go_normal || go_init)) else $error("exit not at once");
  chk_normal_keeps: assert property (@(posedge clock) disable iff (srst) // RQ1
    go_normal |-> !reload_flash) else $error("normal exit reloaded");
  chk_ask_waits: assert property (@(posedge clock) disable iff (srst) // RQ2
    msg_valid && msg_code == `SMX_MSG_MISMATCH |=>
    !go_normal && !go_init && service_active) else $error("left unasked");
  chk_hold_span: assert property (@(posedge clock) disable iff (srst) // RQ3
    announce_s |=> service_active [*8]) else $error("hold cut short");
  chk_quiet_no: assert property (@(posedge clock) disable iff (srst) // RQ12
    answer_no_s |=> msg_valid && msg_code == `SMX_MSG_ABORTED ##1
    prompt_valid && service_active) else $error("no quiet abort");
  chk_restore_plain: assert property (@(posedge clock) disable iff (srst) // RQ13
    load_factory && !flash_write |-> msg_valid &&
    msg_code == `SMX_MSG_APPLIED) else $error("plain restore message");
  chk_warn_limit: assert property (@(posedge clock) disable iff (srst) // RQ17
    flash_write && $past(save_count) >= 16'(SAVE_LIMIT) |->
    msg_valid && msg_code == `SMX_MSG_E004) else $error("no save warning");
  chk_warn_quiet: assert property (@(posedge clock) disable iff (srst) // RQ17
    flash_write && $past(save_count) < 16'(SAVE_LIMIT) |-> !msg_valid)
    else $error("needless save warning");
  chk_saved_msg: assert property (@(posedge clock) disable iff (srst) // RQ15
    state_reg.state == SMX_FLASH && flash_done && flash_ok |=>
    msg_valid && msg_code == `SMX_MSG_SAVED ##1 prompt_valid)
    else $error("no saved message");
endmodule

// ===== verilog/smx_line_mem.sv
// Small store for the characters of one command line
module smx_line_mem #(
  parameter int DEPTH = 4
) (
  input  wire logic                     clock,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [7:0]               rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== verilog/smx_pkg.sv
// Types used by the interpreter; the line store needs none
package smx_pkg;
  typedef enum logic [3:0] {
    SMX_IDLE, SMX_COLLECT, SMX_DECODE, SMX_ASK, SMX_WAIT_ANS,
    SMX_HOLD, SMX_LEAVE, SMX_RESTORE, SMX_FLASH, SMX_PROMPT
  } smx_state_type;
endpackage

// ===== verilog/smx_regs.svh
// Constants for the service-mode exit and restore interpreter
`ifndef SMX_REGS_SVH
`define SMX_REGS_SVH
`define SMX_CHR_CR       8'h0D
`define SMX_CHR_SP       8'h20
`define SMX_CHR_COMMA    8'h2C
`define SMX_CHR_PROMPT   8'h3E
`define SMX_CHR_LC_X     8'h78
`define SMX_CHR_LC_Z     8'h7A
`define SMX_CHR_LC_N     8'h6E
`define SMX_CHR_LC_I     8'h69
`define SMX_CHR_UC_N     8'h4E
`define SMX_CHR_UC_I     8'h49
`define SMX_CHR_LC_S     8'h73
`define SMX_CHR_UC_Y     8'h59
`define SMX_HOLD_MS      3000
`define SMX_CLK_KHZ      20000
`define SMX_SAVE_LIMIT   1000
`define SMX_MSG_NONE     4'h0
`define SMX_MSG_E001     4'h1
`define SMX_MSG_E002     4'h2
`define SMX_MSG_E003     4'h3
`define SMX_MSG_E004     4'h4
`define SMX_MSG_E005     4'h5
`define SMX_MSG_MISMATCH 4'h6
`define SMX_MSG_TO_NORM  4'h7
`define SMX_MSG_TO_INIT  4'h8
`define SMX_MSG_FACTORY  4'h9
`define SMX_MSG_APPLIED  4'hA
`define SMX_MSG_SAVED    4'hB
`define SMX_MSG_ABORTED  4'hC
`define SMX_LINE_DEPTH   4
`endif
